// *** src/swdc_pkg.sv ***
/*
 * swdc_pkg: constants for the supervision down-counter.
 * Assumes a 50 MHz system clock and an 8-bit plain register port.
 */
package swdc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_RELOAD_UPPER = 4'h0;
  localparam logic [3:0] OFF_RELOAD_HIGH  = 4'h1;
  localparam logic [3:0] OFF_RELOAD_LOW   = 4'h2;
  localparam logic [3:0] OFF_CTRL         = 4'h3;
  localparam logic [3:0] OFF_STATUS       = 4'h4;
  localparam logic [3:0] OFF_MASK         = 4'h5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RESP_IRQ_BIT = 0;  // 1 = interrupt, 0 = chip reset
  localparam int CTRL_ON_BIT       = 1;  // read-only running flag
  localparam int ST_TIMEOUT_BIT    = 0;  // time-out taken as interrupt
  localparam int ST_LATE_BIT       = 1;  // refresh ignored near terminal

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  RELOAD_BYTE_RST = 8'hff;
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [1:0]  STATUS_RST      = 2'h0;
  localparam logic [1:0]  MASK_RST        = 2'h0;
  localparam logic [23:0] LATE_LIMIT      = 24'h000002;
  localparam logic [23:0] MIN_RELOAD      = 24'h000004;
  localparam logic [23:0] TERM_COUNT      = 24'h000001;
  localparam int          RC_FREQ_HZ      = 10000;
  localparam int          SYS_FREQ_HZ     = 50000000;

  // ----------------------------------------------------------------
  // run state
  // ----------------------------------------------------------------
  typedef enum logic {
    SWDC_OFF = 1'b0,
    SWDC_ON  = 1'b1
  } swdc_state_e;

endpackage : swdc_pkg

// *** src/swdc_top.sv ***
/*
 * swdc_top: supervision down-counter with register port and interrupt.
 * Assumes the RC oscillator arrives as a slow square wave on a pin and
 * the option bit as a static level; both are synchronised here.
 */
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
module swdc_top #(
  parameter int CNT_W = 24
) (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       ce_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       refresh_instr_i,
  input  wire logic       always_on_option_i,
  input  wire logic       rc_osc_i,
  output logic      [7:0] rdata_o,
  output logic            irq_o,
  output logic            chip_rst_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (CNT_W != 24) begin : g_bad_width
    $error("swdc_top: counter width must be three reload bytes");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0]           rc_sync;      // two sync stages plus edge history
  logic [1:0]           ao_sync;
  swdc_pkg::swdc_state_e state;
  logic                 pend;
  logic [CNT_W-1:0]     count;
  logic [7:0]           reload_upper_byte;
  logic [7:0]           reload_high_byte;
  logic [7:0]           reload_low_byte;
  logic                 resp_irq;
  logic [1:0]           status;
  logic [1:0]           mask;

  logic [2:0]           next_rc_sync;
  logic [1:0]           next_ao_sync;
  swdc_pkg::swdc_state_e next_state;
  logic                 next_pend;
  logic [CNT_W-1:0]     next_count;
  logic [7:0]           next_upper;
  logic [7:0]           next_high;
  logic [7:0]           next_low;
  logic                 next_resp_irq;
  logic [1:0]           next_status;
  logic [1:0]           next_mask;
  logic [7:0]           next_rdata;
  logic                 next_irq;
  logic                 next_chip_rst;

  logic                 tick;
  logic                 term;
  logic                 timeout;
  logic                 late;
  logic [CNT_W-1:0]     reload_val;
  logic [1:0]           clr;

  assign reload_val = {reload_upper_byte, reload_high_byte, reload_low_byte};
  assign tick = rc_sync[1] & ~rc_sync[2];  // stage 0 read by stage 1 only
  assign term = (count <= swdc_pkg::TERM_COUNT);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    next_rc_sync = {rc_sync[1:0], rc_osc_i};
    next_ao_sync = {ao_sync[0], always_on_option_i};
  end

  // ----------------------------------------------------------------
  // counter core
  // ----------------------------------------------------------------
  // refresh request is held until the next oscillator tick, so a fast
  // CPU pulse is never lost between two slow ticks
  always_comb begin
    next_state = state;
    // option bit alone keeps it on
    if (refresh_instr_i || ao_sync[1]) begin
      next_state = swdc_pkg::SWDC_ON;
    end
    next_pend  = refresh_instr_i | (pend & ~tick)
                 | ((state == swdc_pkg::SWDC_OFF) & (next_state == swdc_pkg::SWDC_ON));
    next_count = count;
    timeout    = 1'b0;
    late       = 1'b0;
    unique case (state)
      swdc_pkg::SWDC_OFF: begin
        // enabling is held as a pending reload, so the first load
        // waits for an oscillator tick like any other refresh
        next_count = count;
      end
      swdc_pkg::SWDC_ON: begin
        if (tick) begin
          if (term) begin
            next_count = reload_val;
            timeout    = 1'b1;
          end else if (pend && (count > swdc_pkg::LATE_LIMIT)) begin
            next_count = reload_val;
          end else begin
            next_count = count - {{(CNT_W-1){1'b0}}, 1'b1};
            late       = pend;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register port and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    next_upper    = reload_upper_byte;
    next_high     = reload_high_byte;
    next_low      = reload_low_byte;
    next_resp_irq = resp_irq;
    next_mask     = mask;
    clr           = 2'h0;
    if (wr_i) begin
      unique case (addr_i)
        swdc_pkg::OFF_RELOAD_UPPER: next_upper = wdata_i;
        swdc_pkg::OFF_RELOAD_HIGH:  next_high  = wdata_i;
        swdc_pkg::OFF_RELOAD_LOW:   next_low   = wdata_i;
        swdc_pkg::OFF_CTRL:         next_resp_irq = wdata_i[swdc_pkg::CTRL_RESP_IRQ_BIT];
        swdc_pkg::OFF_STATUS:       clr        = wdata_i[1:0];
        swdc_pkg::OFF_MASK:         next_mask  = wdata_i[1:0];
        default:                    clr        = 2'h0;
      endcase
    end
    // set wins over a write-one clear in the same cycle
    next_status = (status & ~clr);
    next_status[swdc_pkg::ST_TIMEOUT_BIT] = next_status[swdc_pkg::ST_TIMEOUT_BIT]
                                            | (timeout & resp_irq);
    next_status[swdc_pkg::ST_LATE_BIT] = next_status[swdc_pkg::ST_LATE_BIT] | late;
    next_chip_rst = timeout & ~resp_irq;
    next_irq      = |(status & mask);
    next_rdata    = 8'h00;  // unmapped reads return zero
    if (rd_i) begin
      unique case (addr_i)
        swdc_pkg::OFF_RELOAD_UPPER: next_rdata = reload_upper_byte;
        swdc_pkg::OFF_RELOAD_HIGH:  next_rdata = reload_high_byte;
        swdc_pkg::OFF_RELOAD_LOW:   next_rdata = reload_low_byte;
        swdc_pkg::OFF_CTRL:         next_rdata = {6'h00, (state == swdc_pkg::SWDC_ON), resp_irq};
        swdc_pkg::OFF_STATUS:       next_rdata = {6'h00, status};
        swdc_pkg::OFF_MASK:         next_rdata = {6'h00, mask};
        default:                    next_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // ce_i low freezes everything, oscillator history included
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rc_sync           <= 3'h0;
      ao_sync           <= 2'h0;
      state             <= swdc_pkg::SWDC_OFF;
      pend              <= 1'b0;
      count             <= {swdc_pkg::RELOAD_BYTE_RST, swdc_pkg::RELOAD_BYTE_RST,
                            swdc_pkg::RELOAD_BYTE_RST};
      reload_upper_byte <= swdc_pkg::RELOAD_BYTE_RST;
      reload_high_byte  <= swdc_pkg::RELOAD_BYTE_RST;
      reload_low_byte   <= swdc_pkg::RELOAD_BYTE_RST;
      resp_irq          <= swdc_pkg::CTRL_RST[swdc_pkg::CTRL_RESP_IRQ_BIT];
      status            <= swdc_pkg::STATUS_RST;
      mask              <= swdc_pkg::MASK_RST;
      rdata_o           <= 8'h00;
      irq_o             <= 1'b0;
      chip_rst_o        <= 1'b0;
    end else if (ce_i) begin
      rc_sync           <= next_rc_sync;
      ao_sync           <= next_ao_sync;
      state             <= next_state;
      pend              <= next_pend;
      count             <= next_count;
      reload_upper_byte <= next_upper;
      reload_high_byte  <= next_high;
      reload_low_byte   <= next_low;
      resp_irq          <= next_resp_irq;
      status            <= next_status;
      mask              <= next_mask;
      rdata_o           <= next_rdata;
      irq_o             <= next_irq;
      chip_rst_o        <= next_chip_rst;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i || !ce_i);

  property p_refresh_reload;
    tick && pend && state == swdc_pkg::SWDC_ON && count > 24'h000002
    |=> count == {$past(reload_upper_byte), $past(reload_high_byte), $past(reload_low_byte)};
  endproperty
  a_refresh_reload: assert property (p_refresh_reload)
    else $error("refresh did not reload counter");

  property p_late_ignored;
    tick && pend && state == swdc_pkg::SWDC_ON && count == 24'h000002 |=> count == 24'h000001;
  endproperty
  a_late_ignored: assert property (p_late_ignored)
    else $error("late refresh was not ignored");

  property p_decrement;
    tick && !pend && state == swdc_pkg::SWDC_ON && count > 24'h000001
    |=> count == $past(count) - 24'h000001;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not step down on tick");

  property p_hold_no_tick;
    !tick && state == swdc_pkg::SWDC_ON |=> count == $past(count);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick)
    else $error("counter moved without oscillator tick");

  property p_timeout_irq;
    tick && term && state == swdc_pkg::SWDC_ON && resp_irq
    |=> status[0] && !chip_rst_o ##1 irq_o || !mask[0];
  endproperty
  a_timeout_irq: assert property (p_timeout_irq)
    else $error("interrupt response missing");

  property p_timeout_rst;
    tick && term && state == swdc_pkg::SWDC_ON && !resp_irq |=> chip_rst_o ##1 !chip_rst_o;
  endproperty
  a_timeout_rst: assert property (p_timeout_rst)
    else $error("reset response missing or not one cycle");

  property p_enable;
    refresh_instr_i |=> state == swdc_pkg::SWDC_ON;
  endproperty
  a_enable: assert property (p_enable)
    else $error("instruction did not enable timer");

  property p_always_on;
    ao_sync[1] |=> state == swdc_pkg::SWDC_ON [*3];
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("option bit did not keep timer on");

  property p_pend_waits;
    refresh_instr_i && !tick |=> pend && count == $past(count);
  endproperty
  a_pend_waits: assert property (p_pend_waits)
    else $error("refresh acted before oscillator tick");

  // the option path must defer its first reload as the instruction does
  property p_enable_pend;
    state == swdc_pkg::SWDC_OFF && ao_sync[1] |=> state == swdc_pkg::SWDC_ON && pend;
  endproperty
  a_enable_pend: assert property (p_enable_pend)
    else $error("option enable did not wait for a tick");

  property p_late_flag;
    tick && pend && state == swdc_pkg::SWDC_ON && count == 24'h000002 |=> status[1];
  endproperty
  a_late_flag: assert property (p_late_flag)
    else $error("ignored refresh was not flagged");

  c_timeout_irq:  cover property (tick && term && state == swdc_pkg::SWDC_ON && resp_irq);
  c_timeout_rst:  cover property (chip_rst_o);
  c_late_refresh: cover property (late);
  c_refresh:      cover property (tick && pend && count > 24'h000002);
  c_option_on:    cover property (state == swdc_pkg::SWDC_OFF && ao_sync[1]);

endmodule : swdc_top

// *** sim/swdc_top_test.sv ***
/*
 * swdc_top_test: self-checking bench for the supervision down-counter.
 * Assumes one 50 MHz clock; the bench makes a fast oscillator square wave.
 */
`timescale 1ns/10ps
module swdc_top_test;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic       clk_i;
  logic       arst_n_i;
  logic       ce_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic       refresh_instr_i;
  logic       always_on_option_i;
  logic       rc_osc_i;
  logic [7:0] rdata_o;
  logic       irq_o;
  logic       chip_rst_o;
  int         bad_count;
  int         compares;
  int         rst_pulses;
  logic [7:0] rd_val;

  swdc_top #(.CNT_W(24)) swdc_top_i (
    .clk_i              (clk_i),
    .arst_n_i           (arst_n_i),
    .ce_i               (ce_i),
    .addr_i             (addr_i),
    .wdata_i            (wdata_i),
    .wr_i               (wr_i),
    .rd_i               (rd_i),
    .refresh_instr_i    (refresh_instr_i),
    .always_on_option_i (always_on_option_i),
    .rc_osc_i           (rc_osc_i),
    .rdata_o            (rdata_o),
    .irq_o              (irq_o),
    .chip_rst_o         (chip_rst_o)
  );

  // clock generation, 20 ns period
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // chip reset is a one-cycle pulse, so count it as it happens
  always @(posedge clk_i) begin
    if (chip_rst_o === 1'b1) rst_pulses++;
  end

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 rd_val = rdata_o;
  endtask : rd

  // n oscillator periods, each slow enough for the two-flop sampler
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i) rc_osc_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rc_osc_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
    #1;
  endtask : tick

  task automatic refresh();
    @(posedge clk_i) refresh_instr_i <= 1'b1;
    @(posedge clk_i) refresh_instr_i <= 1'b0;
  endtask : refresh

  task automatic do_reset();
    @(posedge clk_i) arst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask : do_reset

  task automatic load_reload(input logic [7:0] u, input logic [7:0] h, input logic [7:0] l);
    // callers keep reload at four or more
    wr(swdc_pkg::OFF_RELOAD_UPPER, u);
    wr(swdc_pkg::OFF_RELOAD_HIGH, h);
    wr(swdc_pkg::OFF_RELOAD_LOW, l);
  endtask : load_reload

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rd(swdc_pkg::OFF_RELOAD_UPPER); chk8("upper", rd_val, 8'hff);
    rd(swdc_pkg::OFF_RELOAD_HIGH);  chk8("high", rd_val, 8'hff);
    rd(swdc_pkg::OFF_RELOAD_LOW);   chk8("low", rd_val, 8'hff);
    // read data stand one cycle only, then fall back to zero
    @(posedge clk_i);
    #1 chk8("rdata idle", rdata_o, 8'h00);
    rd(swdc_pkg::OFF_CTRL);         chk8("ctrl", rd_val, 8'h00);
    rd(swdc_pkg::OFF_STATUS);       chk8("status", rd_val, 8'h00);
    rd(swdc_pkg::OFF_MASK);         chk8("mask", rd_val, 8'h00);
    wr(4'h9, 8'h5a);
    rd(4'h9);                       chk8("unmapped", rd_val, 8'h00);
    $display("test reset_values done");
  endtask : t_reset_values

  // masked timeout, then unmask and clear
  task automatic t_irq_timeout();
    load_reload(8'h00, 8'h00, 8'h04);
    wr(swdc_pkg::OFF_CTRL, 8'h01);
    refresh();
    rd(swdc_pkg::OFF_CTRL);   chk8("ctrl on", rd_val, 8'h03);
    // the enabling instruction is a refresh too: the first tick reloads
    tick(4);
    rd(swdc_pkg::OFF_STATUS); chk8("early", rd_val, 8'h00);
    tick(1);
    rd(swdc_pkg::OFF_STATUS); chk8("timeout", rd_val, 8'h01);
    chk8("irq masked", {7'h00, irq_o}, 8'h00);
    wr(swdc_pkg::OFF_MASK, 8'h01);
    rd(swdc_pkg::OFF_MASK);   chk8("mask", rd_val, 8'h01);
    repeat (3) @(posedge clk_i);
    #1 chk8("irq on", {7'h00, irq_o}, 8'h01);
    wr(swdc_pkg::OFF_STATUS, 8'h01);
    repeat (3) @(posedge clk_i);
    #1 chk8("irq clr", {7'h00, irq_o}, 8'h00);
    $display("test irq_timeout done");
  endtask : t_irq_timeout

  // a refresh at count three restarts the full period
  task automatic t_refresh();
    tick(1);
    refresh();
    tick(4);
    rd(swdc_pkg::OFF_STATUS); chk8("restarted", rd_val, 8'h00);
    tick(1);
    rd(swdc_pkg::OFF_STATUS); chk8("after", rd_val, 8'h01);
    wr(swdc_pkg::OFF_STATUS, 8'h03);
    $display("test refresh done");
  endtask : t_refresh

  // a refresh at count two is dropped and flagged
  task automatic t_late();
    tick(2);
    refresh();
    tick(1);
    rd(swdc_pkg::OFF_STATUS); chk8("late", rd_val, 8'h02);
    tick(1);
    rd(swdc_pkg::OFF_STATUS); chk8("late to", rd_val, 8'h03);
    $display("test late_refresh done");
  endtask : t_late

  // option bit alone runs the timer; first tick loads, 256 more time out
  task automatic t_always_on();
    do_reset();
    load_reload(8'h00, 8'h01, 8'h00);
    @(posedge clk_i) always_on_option_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(swdc_pkg::OFF_CTRL); chk8("ao on", rd_val, 8'h02);
    rst_pulses = 0;
    tick(256);
    chk8("no rst", rst_pulses[7:0], 8'h00);
    // clock enable low: an oscillator period passes unseen
    @(posedge clk_i) ce_i <= 1'b0;
    tick(1);
    chk8("frozen", rst_pulses[7:0], 8'h00);
    @(posedge clk_i) ce_i <= 1'b1;
    tick(1);
    chk8("rst", rst_pulses[7:0], 8'h01);
    chk8("no irq", {7'h00, irq_o}, 8'h00);
    $display("test always_on done");
  endtask : t_always_on

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // watchdog; the whole run needs well under 100 us
  initial begin
    #500us;
    bad_count++;
    end_sim();
  end

  initial begin
    bad_count = 0;
    compares = 0;
    rst_pulses = 0;
    arst_n_i = 1'b0;
    ce_i = 1'b1;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    refresh_instr_i = 1'b0;
    always_on_option_i = 1'b0;
    rc_osc_i = 1'b0;
    do_reset();
    t_reset_values();
    t_irq_timeout();
    t_refresh();
    t_late();
    t_always_on();
    end_sim();
  end
endmodule : swdc_top_test
